// ### rtl/reset_manager.sv
// reset distribution, sleep and standby control, watchdog, cause register
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module reset_manager
#(
  // 1: reset pin acts as a full cold reset, 0: older behaviour, global plus enabled port-config reset
  parameter bit pin_is_cold = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire reset_manager_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic reset_pin,
  input wire logic port_a_combo,
  input wire logic wdg_tick,
  input wire logic bad_address,
  input wire logic halt_req,
  input wire logic wake_req,
  output reset_manager_pkg::reset_bus_t resets,
  output logic cpu_run,
  output logic clocks_run,
  output logic force_rc_on,
  output reset_manager_pkg::op_mode_t mode
);

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic porta_meta;
  logic porta_sync;

  always_ff @(posedge clk)
  begin
    pin_meta <= reset_pin;
    pin_sync <= pin_meta;
    porta_meta <= port_a_combo;
    porta_sync <= porta_meta;
  end

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic hit(input reset_manager_pkg::reg_req_t r,
                               input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  logic wr_ctrl;
  logic wr_cause;
  logic wr_wdg;
  logic wr_dormant;
  assign wr_ctrl = hit(req, reset_manager_pkg::reg_reset_control);
  assign wr_cause = hit(req, reset_manager_pkg::reg_reset_cause);
  assign wr_wdg = hit(req, reset_manager_pkg::reg_wdg_service);
  assign wr_dormant = hit(req, reset_manager_pkg::reg_dormant_status);

  // ----------------------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------------------
  logic sleep_unlock;
  logic port_cfg_reset_enable;
  logic bad_address_reset_enable;
  logic wdg_reset_enable;
  logic [3:0] wdg_count;
  logic wdg_armed;
  reset_manager_pkg::op_mode_t state;

  logic src_wdg;
  logic src_bad;
  logic src_porta;
  logic src_pin;
  logic cold_src;
  logic pconf_src;
  logic sys_src;

  assign src_pin = pin_sync;
  assign src_porta = porta_sync;
  assign src_wdg = wdg_reset_enable &&
                   (wdg_count == reset_manager_pkg::wdg_count_trip);
  assign src_bad = bad_address_reset_enable && bad_address;
  assign cold_src = rst || (pin_is_cold && src_pin);
  assign pconf_src = src_wdg || src_bad || src_porta ||
                     (!pin_is_cold && src_pin);
  assign sys_src = cold_src || pconf_src || src_pin;

  // ----------------------------------------------------------------------------
  // internal reset outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resets <= '1;
    end
    else
    begin
      resets.cold <= cold_src;
      resets.system <= sys_src;
      resets.pconf <= cold_src ||
                      (pconf_src && port_cfg_reset_enable);
      // sleep request alone raises only the dormant reset
      resets.sleep <= cold_src ||
                      (state == reset_manager_pkg::mode_sleep);
    end
  end

  // ----------------------------------------------------------------------------
  // reset control register
  // ----------------------------------------------------------------------------
  // cold bits survive port A wake since only cold reset clears them
  always_ff @(posedge clk)
  begin
    if (cold_src)
    begin
      sleep_unlock <= 1'b0;
      port_cfg_reset_enable <= 1'b0;
      bad_address_reset_enable <= 1'b0;
      wdg_reset_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sleep_unlock <= req.wdata[reset_manager_pkg::bit_sleep_unlock];
      port_cfg_reset_enable <=
        req.wdata[reset_manager_pkg::bit_port_cfg_reset_enable];
      bad_address_reset_enable <=
        req.wdata[reset_manager_pkg::bit_bad_address_reset_enable];
      wdg_reset_enable <= wdg_reset_enable ||
        req.wdata[reset_manager_pkg::bit_wdg_reset_enable];
    end
  end

  // ----------------------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------------------
  logic sleep_write;
  assign sleep_write = wr_cause && sleep_unlock &&
                       req.wdata[reset_manager_pkg::bit_sleep_request];

  always_ff @(posedge clk)
  begin
    if (cold_src)
    begin
      state <= reset_manager_pkg::mode_active;
    end
    else
    begin
      unique case (state)
        reset_manager_pkg::mode_active:
        begin
          if (sleep_write && !sys_src)
          begin
            state <= reset_manager_pkg::mode_sleep;
          end
          else if (halt_req && !sys_src)
          begin
            state <= reset_manager_pkg::mode_standby;
          end
        end
        reset_manager_pkg::mode_standby:
        begin
          if (sys_src || wake_req)
          begin
            state <= reset_manager_pkg::mode_active;
          end
        end
        reset_manager_pkg::mode_sleep:
        begin
          // watchdog and bus sources are frozen here, only pins wake
          if (src_pin || src_porta)
          begin
            state <= reset_manager_pkg::mode_active;
          end
        end
        default:
        begin
          state <= reset_manager_pkg::mode_active;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode <= reset_manager_pkg::mode_active;
      cpu_run <= 1'b0;
      clocks_run <= 1'b1;
      force_rc_on <= 1'b1;
    end
    else
    begin
      mode <= state;
      cpu_run <= (state == reset_manager_pkg::mode_active) &&
                 !sys_src;
      clocks_run <= (state != reset_manager_pkg::mode_sleep);
      force_rc_on <= cold_src;
    end
  end

  // ----------------------------------------------------------------------------
  // reset cause register
  // ----------------------------------------------------------------------------
  logic [4:0] cause;
  logic [4:0] cause_set;
  logic in_sleep;
  assign in_sleep = (state == reset_manager_pkg::mode_sleep);
  assign cause_set = {src_bad, src_wdg, src_porta, src_pin,
                      src_pin && in_sleep};

  // set wins over the clearing write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cause <= reset_manager_pkg::cause_reset_value;
    end
    else if (wr_cause)
    begin
      cause <= cause_set;
    end
    else
    begin
      cause <= cause | cause_set;
    end
  end

  logic dormant_seen_flag;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dormant_seen_flag <= 1'b0;
    end
    else
    begin
      dormant_seen_flag <= in_sleep || (dormant_seen_flag && !wr_dormant);
    end
  end

  // ----------------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------------
  logic key_match;
  assign key_match = wr_wdg && wdg_armed &&
                     (req.wdata == reset_manager_pkg::wdg_key_second);

  always_ff @(posedge clk)
  begin
    if (cold_src)
    begin
      wdg_armed <= 1'b0;
    end
    else if (wr_wdg)
    begin
      wdg_armed <= (req.wdata == reset_manager_pkg::wdg_key_first);
    end
  end

  // counter also clears on its own trip, else the reset would repeat forever
  always_ff @(posedge clk)
  begin
    if (cold_src || sys_src || key_match)
    begin
      wdg_count <= reset_manager_pkg::wdg_count_zero;
    end
    else if (wdg_reset_enable && wdg_tick && !in_sleep)
    begin
      wdg_count <= wdg_count + reset_manager_pkg::wdg_count_one;
    end
  end

  // ----------------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = reset_manager_pkg::reset_value;
    if (req.rd)
    begin
      unique case (req.addr)
        reset_manager_pkg::reg_reset_control:
        begin
          next_rdata = {sleep_unlock, port_cfg_reset_enable,
                        bad_address_reset_enable, wdg_reset_enable,
                        reset_manager_pkg::ctrl_reset_value};
        end
        reset_manager_pkg::reg_reset_cause:
        begin
          next_rdata = {2'b00, cause, 1'b0};
        end
        reset_manager_pkg::reg_wdg_service:
        begin
          next_rdata = {4'h0, wdg_count};
        end
        reset_manager_pkg::reg_dormant_status:
        begin
          next_rdata = {7'h00, dormant_seen_flag};
        end
        default:
        begin
          next_rdata = reset_manager_pkg::reset_value;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= reset_manager_pkg::reset_value;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // the core leaves one idle slot between bus cycles
  sequence s_key_pair;
    wr_wdg && req.wdata == reset_manager_pkg::wdg_key_first
    ##1 !wr_wdg
    ##1 wr_wdg && req.wdata == reset_manager_pkg::wdg_key_second;
  endsequence

  sequence s_sleep_entry;
    wr_ctrl && req.wdata[reset_manager_pkg::bit_sleep_unlock]
    ##1 !wr_ctrl
    ##1 sleep_write && !sys_src && state == reset_manager_pkg::mode_active;
  endsequence

  a_cold_reset_only: assert property (@(posedge clk) disable iff (rst)
    resets.cold |-> $past(rst) || (pin_is_cold && $past(pin_sync)))
    else $error("cold reset without power-on");

  a_system_follows: assert property (@(posedge clk) disable iff (rst)
    sys_src |=> resets.system)
    else $error("global reset missed a source");

  a_pconf_gated: assert property (@(posedge clk) disable iff (rst)
    resets.pconf |-> $past(sys_src) && ($past(cold_src) ||
      $past(port_cfg_reset_enable)))
    else $error("port config reset without enable");

  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    s_sleep_entry |=> state == reset_manager_pkg::mode_sleep
      ##1 resets.sleep)
    else $error("sleep not entered");

  a_sleep_locked: assert property (@(posedge clk) disable iff (rst)
    wr_cause && !sleep_unlock && state == reset_manager_pkg::mode_active
      && !halt_req |=> state == reset_manager_pkg::mode_active)
    else $error("sleep entered while locked");

  a_sleep_exit: assert property (@(posedge clk) disable iff (rst)
    in_sleep && !src_pin && !src_porta && !cold_src |=> in_sleep)
    else $error("sleep left without wake source");

  a_wdg_lock: assert property (@(posedge clk) disable iff (rst)
    wdg_reset_enable && !cold_src |=> wdg_reset_enable)
    else $error("watchdog enable dropped");

  a_wdg_clear: assert property (@(posedge clk) disable iff (rst)
    s_key_pair |=> wdg_count == reset_manager_pkg::wdg_count_zero)
    else $error("watchdog not cleared by key pair");

  a_wdg_trip: assert property (@(posedge clk) disable iff (rst)
    src_wdg |=> resets.system &&
      wdg_count == reset_manager_pkg::wdg_count_zero)
    else $error("watchdog trip missed");

  a_dormant_flag: assert property (@(posedge clk) disable iff (rst)
    in_sleep |=> dormant_seen_flag [*2])
    else $error("dormant flag not set");

  a_cause_read: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == reset_manager_pkg::reg_reset_cause
      |=> !rdata[7] && !rdata[6] && !rdata[0])
    else $error("sleep request bit read back");

  a_clock_stop: assert property (@(posedge clk) disable iff (rst)
    in_sleep |=> !clocks_run && !cpu_run)
    else $error("clocks running in sleep");

endmodule // reset_manager

`default_nettype wire

// ### rtl/reset_manager_pkg.sv
// constants, types and register map of the reset and sleep manager
// ----------------------------------------------------------------------------
// Overview of operation
// - power-on clears all state, forces RC on, crystal off, core held
// - other resets clear system and enabled port-config bits, core reset
// - halt enters standby; any reset or enabled wake request ends it
// - sleep stops all clocks and peripherals, no time keeping
// - sleep ends only on power-on, reset pin, or port A combination
// - port A wake keeps every cold-reset bit unchanged
// - dormant-seen flag reads 1 if sleep occurred since last clear
// - control register: unlock 7, pconf 6, bad address 5, watchdog 4
// - watchdog enable cannot be cleared by software once set
// - sleep request at cause bit 7 always reads 0
// - cause flags at bits 5..1 clear only on power-up or by write
// - five reset sources: power, pin, port A, watchdog, bad address
// - cold reset asserted on power-on reset, and on the reset pin if pin_is_cold
// - global reset asserted on cold or any enabled reset source
// - port-config reset with cold reset, or with global reset and its enable set
// - dormant reset held for the whole sleep, nothing else from it
// - pin asserts all four resets on newer part, fewer on older
// - sleep request is a software reset source used only for sleep
// - sleep request ignored while sleep unlock is 0
// - watchdog cleared only by 0x0a then 0x03, consecutive writes; the counter also clears on every global reset
// - watchdog counts 0 to 7, resets the system on reaching 8
// ----------------------------------------------------------------------------
package reset_manager_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0] reg_reset_control = 8'h00;
  localparam logic [7:0] reg_reset_cause = 8'h01;
  localparam logic [7:0] reg_wdg_service = 8'h02;
  localparam logic [7:0] reg_dormant_status = 8'h03;

  localparam int bit_sleep_unlock = 7;
  localparam int bit_port_cfg_reset_enable = 6;
  localparam int bit_bad_address_reset_enable = 5;
  localparam int bit_wdg_reset_enable = 4;

  localparam int bit_sleep_request = 7;
  localparam int bit_bad_address_cause_flag = 5;
  localparam int bit_wdg_cause_flag = 4;
  localparam int bit_port_a_cause_flag = 3;
  localparam int bit_pin_cause_flag = 2;
  localparam int bit_pin_wake_cause_flag = 1;
  localparam int bit_dormant_seen_flag = 0;

  localparam logic [7:0] reset_value = 8'h00;
  localparam logic [3:0] ctrl_reset_value = 4'h0;
  localparam logic [4:0] cause_reset_value = 5'h00;

  // ----------------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------------
  localparam logic [7:0] wdg_key_first = 8'h0a;
  localparam logic [7:0] wdg_key_second = 8'h03;
  localparam logic [3:0] wdg_count_zero = 4'h0;
  localparam logic [3:0] wdg_count_one = 4'h1;
  localparam logic [3:0] wdg_count_trip = 4'h8;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    mode_active = 3'b001,
    mode_standby = 3'b010,
    mode_sleep = 3'b100
  } op_mode_t;

  typedef struct packed
  {
    logic cold;
    logic system;
    logic pconf;
    logic sleep;
  } reset_bus_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ### dv/core_model.sv
// processor core model that issues register bus cycles
`timescale 1ns/1ps
`default_nettype none

module core_model
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var reset_manager_pkg::reg_req_t req
);
  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  initial
  begin
    req = 18'h0;
  end

  // released lines show the inverse, so a stale address never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask

  // ---------------------------------------------------------------------------
  // sleep entry
  // ---------------------------------------------------------------------------
  // oscillator bias lives in the clock block, left as is here
  task automatic sleep_entry();
    wr(reset_manager_pkg::reg_reset_control, 8'h80);
    wr(reset_manager_pkg::reg_reset_cause, 8'h80);
    @(posedge clk); // idle slot, may run on a port A wake
  endtask
endmodule // core_model
`default_nettype wire

// ### dv/tb.sv
// self-checking testbench of the reset and sleep manager
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [7:0] ctl = reset_manager_pkg::reg_reset_control;
  localparam logic [7:0] cse = reset_manager_pkg::reg_reset_cause;
  localparam logic [7:0] wdg = reset_manager_pkg::reg_wdg_service;
  localparam logic [7:0] dor = reset_manager_pkg::reg_dormant_status;
  localparam int i_pin = 5;
  localparam int i_pa = 4;
  localparam int i_tick = 3;
  localparam int i_bad = 2;
  localparam int i_halt = 1;
  localparam int i_wake = 0;
  logic clk;
  logic rst;
  logic [5:0] src;
  logic reset_pin, port_a_combo, wdg_tick, bad_address, halt_req, wake_req;
  reset_manager_pkg::reg_req_t req;
  reset_manager_pkg::reset_bus_t resets;
  reset_manager_pkg::op_mode_t mode;
  logic [7:0] rdata;
  logic cpu_run, clocks_run, force_rc_on, clr;
  logic [4:0] saw;
  int err_count;
  int cmp_count;

  assign {reset_pin, port_a_combo, wdg_tick, bad_address, halt_req,
    wake_req} = src;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // sticky record of reset outputs, catches one-cycle reset pulses
  always @(posedge clk)
    saw <= clr ? 5'h00 : (saw | {force_rc_on, resets});

  reset_manager #(.pin_is_cold(1'b1)) uut (.clk(clk), .rst(rst),
    .req(req), .rdata(rdata), .reset_pin(reset_pin),
    .port_a_combo(port_a_combo), .wdg_tick(wdg_tick),
    .bad_address(bad_address), .halt_req(halt_req), .wake_req(wake_req),
    .resets(resets), .cpu_run(cpu_run), .clocks_run(clocks_run),
    .force_rc_on(force_rc_on), .mode(mode));

  core_model core (.clk(clk), .rdata(rdata), .req(req));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    core.rd(a, v);
    chk($sformatf("register %h", a), e, v);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int k, input int n);
    @(posedge clk);
    src[k] <= 1'b1;
    repeat (n) @(posedge clk);
    src[k] <= 1'b0;
  endtask

  task automatic clr_saw();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic chk_mode(input logic [7:0] e);
    chk("mode", e, {5'h0, mode});
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    chk("resets held", 8'h0f, {4'h0, resets});
    chk("rc forced", 8'h01, {7'h0, force_rc_on});
    chk("core run", 8'h00, {7'h0, cpu_run});
    @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk("resets idle", 8'h00, {4'h0, resets});
    chk_mode(8'h01);
    rchk(ctl, 8'h00);
    rchk(cse, 8'h00);
    rchk(wdg, 8'h00);
  endtask

  task automatic t_regs();
    core.wr(ctl, 8'h6f);
    rchk(ctl, 8'h60);
    cyc(1);
    chk("rdata idle", 8'h00, rdata);
    core.wr(ctl, 8'h9f);
    core.wr(ctl, 8'h00);
    rchk(ctl, 8'h10);
    core.wr(cse, 8'h80);
    cyc(4);
    chk_mode(8'h01);
    rchk(cse, 8'h00);
    core.wr(8'h10, 8'h5a);
    rchk(8'h10, 8'h00);
  endtask

  task automatic t_standby();
    pulse(i_halt, 1);
    cyc(3);
    chk_mode(8'h02);
    chk("run flags", 8'h01, {6'h0, cpu_run, clocks_run});
    pulse(i_wake, 2);
    cyc(3);
    chk_mode(8'h01);
  endtask

  task automatic t_src();
    logic [7:0] tc [5];
    int ts [5];
    logic [7:0] te [5];
    logic [7:0] tf [5];
    tc = '{8'h00, 8'h20, 8'h60, 8'h00, 8'h40};
    ts = '{i_bad, i_bad, i_bad, i_pa, i_pa};
    te = '{8'h00, 8'h04, 8'h06, 8'h04, 8'h06};
    tf = '{8'h00, 8'h20, 8'h20, 8'h08, 8'h08};
    for (int i = 0; i < 5; i++)
    begin
      core.wr(ctl, tc[i]);
      core.wr(cse, 8'h00);
      clr_saw();
      pulse(ts[i], 4);
      cyc(6);
      chk("seen resets", te[i], {3'h0, saw});
      rchk(cse, tf[i]);
      rchk(ctl, tc[i] | 8'h10);
    end
  endtask

  task automatic t_wdg();
    repeat (3) pulse(i_tick, 1);
    rchk(wdg, 8'h03);
    core.wr(wdg, 8'h0a);
    core.wr(wdg, 8'h05);
    core.wr(wdg, 8'h03);
    rchk(wdg, 8'h03);
    core.wr(wdg, 8'h0a);
    core.wr(wdg, 8'h03);
    rchk(wdg, 8'h00);
    core.wr(cse, 8'h00);
    clr_saw();
    repeat (7) pulse(i_tick, 1);
    rchk(wdg, 8'h07);
    chk("seen resets", 8'h00, {3'h0, saw});
    pulse(i_tick, 1);
    cyc(3);
    chk("seen resets", 8'h06, {3'h0, saw});
    rchk(cse, 8'h10);
    rchk(wdg, 8'h00);
  endtask

  task automatic t_sleep();
    core.wr(cse, 8'h00);
    core.sleep_entry();
    cyc(3);
    chk_mode(8'h04);
    chk("run flags", 8'h00, {6'h0, cpu_run, clocks_run});
    chk("resets", 8'h01, {4'h0, resets});
    clr_saw();
    pulse(i_wake, 3);
    pulse(i_halt, 1);
    cyc(3);
    chk_mode(8'h04);
    pulse(i_pa, 4);
    cyc(6);
    chk_mode(8'h01);
    chk("seen resets", 8'h05, {3'h0, saw});
    rchk(ctl, 8'h90);
    rchk(cse, 8'h08);
    rchk(dor, 8'h01);
    core.wr(dor, 8'h00);
    rchk(dor, 8'h00);
    core.wr(cse, 8'h00);
    core.sleep_entry();
    cyc(3);
    clr_saw();
    pulse(i_pin, 4);
    cyc(6);
    chk("seen resets", 8'h1f, {3'h0, saw});
    chk_mode(8'h01);
    rchk(ctl, 8'h00);
    rchk(cse, 8'h06);
  endtask

  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // far above the few hundred cycles the scenarios need
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    src = 6'h00;
    clr = 1'b0;
    err_count = 0;
    cmp_count = 0;
    t_reset();
    t_regs();
    t_standby();
    t_src();
    t_wdg();
    t_sleep();
    t_reset();
    complete_run();
  end
endmodule // tb
`default_nettype wire
